// file: src/pcs_regs.svh
/*
  Register indices, field positions, reset values and timing counts for the
  peripheral clock-stop and reset controller. Assumes 32-bit AXI4-Lite access
  where the byte address is four times the register index.
*/
// What this block does
// - With strap low, clocks stay blocked at least 10 ms while the oscillator settles.
// - With strap low, a stabilisation counter holds clocks off and releases them only at terminal count.
// - With strap low, the crystal oscillator feeds the PLL reference.
// - Writing a bit of the reset control register resets that peripheral.
// - Each triggered peripheral reset stays low for the programmed cycle count, or for one cycle when that count is zero.
// - Clock-stop register holds request and acknowledge bits for six peripherals.
// - Peripheral finishes its bus transfer before acknowledging; clock stops only then.
// - Host port, buffered serial port and UART clocks idle when acknowledge appears.
// - Clock gating bits take effect at once, no idle step needed.
// - All I/O pins are high impedance while chip reset is low.
// - Pins leave high impedance 65535 cycles (strap high) or 131071 (strap low) after reset.
// - Every bidirectional pin has its own pull enable bit in a config register.
// - Pull enables act independently of the function routed to the pin.
// - Every pull resistor is enabled out of reset.
// - With strap high, the external clock pin feeds the PLL and the oscillator is turned off once the strap is captured.
`ifndef PCS_REGS_SVH
`define PCS_REGS_SVH

// Register indices
`define PCS_IDX_GATE_LO 16'h1c02
`define PCS_IDX_GATE_HI 16'h1c03
`define PCS_IDX_RST_CTRL 16'h1c04
`define PCS_IDX_RST_CNT 16'h1c05
`define PCS_IDX_PULL_SER 16'h1c17
`define PCS_IDX_PULL_MISC 16'h1c18
`define PCS_IDX_CLK_STOP 16'h1c3a
`define PCS_IDX_STATUS 16'h1c3b
`define PCS_IDX_PULL_MEM_D 16'h1c4c
`define PCS_IDX_PULL_MEM_A 16'h1c4d
`define PCS_IDX_PULL_MEM_C 16'h1c4f
`define PCS_IDX_PULL_SDR_HOST 16'h1c50

// Reset values
`define PCS_PULL_RST 16'hffff
`define PCS_GATE_RST 16'h0000
`define PCS_RST_CNT_RST 16'h0020
`define PCS_CS_REQ_RST 6'h00

// Clock-stop register fields
`define PCS_CS_ACK_LSB 8
`define PCS_HS_NUM 6
// Handshake peripherals whose clock idles with the acknowledge
`define PCS_HS_AUTO_IDLE 6'h34

// Status register fields
`define PCS_ST_RELEASED 0
`define PCS_ST_IO_HIZ 1
`define PCS_ST_STRAP 2
`define PCS_ST_OSC_EN 3

// Timing
`define PCS_CLK_MHZ 200
`define PCS_STAB_TIME_MS 10
`define PCS_STAB_CYC (`PCS_STAB_TIME_MS * `PCS_CLK_MHZ * 1000)
`define PCS_IO_HIZ_CYC_HI 65535
`define PCS_IO_HIZ_CYC_LO 131071
`define PCS_STRAP_FILL 3'h4

// Bus answers
`define PCS_RESP_OKAY 2'h0
`define PCS_RESP_SLVERR 2'h2

`endif

// file: src/pcs_pkg.sv
/*
  Types shared by the clock-stop and reset controller.
  Assumes pcs_regs.svh supplies all numeric constants.
*/
package pcs_pkg;
  // Start-up sequencing, Gray coded along strap -> wait -> run
  typedef enum logic [1:0] {
    BOOT_STRAP = 2'h0,
    BOOT_WAIT = 2'h1,
    BOOT_RUN = 2'h3
  } pcs_boot_e;

  // A register write ready to commit
  typedef struct packed {
    logic [15:0] idx;
    logic [15:0] data;
    logic [1:0] strb;
  } pcs_wr_s;
endpackage

// file: src/pcs_sync3.sv
/*
  Three-stage input synchroniser with agreement filter.
  Assumes an asynchronous input and a clock enable that freezes it.
*/
`timescale 1ns/1ps
`default_nettype none
module pcs_sync3 #(
  parameter int W = 1
) (
  input wire logic clk_in, // Clock
  input wire logic rst_n_in, // Async reset, active low
  input wire logic ce_in, // Clock enable
  input wire logic [W-1:0] d_in, // Asynchronous input
  output logic [W-1:0] q_out // Filtered value
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // Shift chain; first stage feeds only the second
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else if (ce_in) begin
      s1 <= d_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Accept a change once stages two and three agree
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q_out <= '0;
    end else if (ce_in && (s2 == s3)) begin
      q_out <= s3;
    end
  end
endmodule
`default_nettype wire

// file: src/pcs_rst_cnt.sv
/*
  One counted software reset for a single peripheral.
  Assumes start is a one-cycle pulse on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pcs_rst_cnt #(
  parameter int CW = 16
) (
  input wire logic clk_in, // Clock
  input wire logic rst_n_in, // Async reset, active low
  input wire logic ce_in, // Clock enable
  input wire logic start_in, // Trigger pulse
  input wire logic [CW-1:0] count_in, // Cycles to hold reset
  output logic rst_n_out, // Peripheral reset, active low
  output logic busy_out // Reset in progress
);
  logic [CW-1:0] cnt;
  logic [CW-1:0] len_q;
  logic [CW-1:0] low_cnt;
  logic [CW-1:0] next_len;

  // Zero count still gives one cycle of reset
  assign next_len = (count_in == '0) ? CW'(1) : count_in;

  // Count down while the reset is held low
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= '0;
      rst_n_out <= 1'b1;
    end else if (ce_in) begin
      if (start_in) begin
        cnt <= next_len;
        rst_n_out <= 1'b0;
      end else if (!rst_n_out) begin
        cnt <= cnt - CW'(1);
        if (cnt == CW'(1)) begin
          rst_n_out <= 1'b1;
        end
      end
    end
  end

  assign busy_out = !rst_n_out;

  // Checking aid: length requested and cycles actually held
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      len_q <= '0;
      low_cnt <= '0;
    end else if (ce_in) begin
      if (start_in) begin
        len_q <= next_len;
        low_cnt <= '0;
      end else if (!rst_n_out) begin
        low_cnt <= low_cnt + CW'(1);
      end
    end
  end

  AST_RST_START: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (start_in && ce_in) |=> !rst_n_out)
    else $error("Peripheral reset did not assert on trigger");

  AST_RST_LEN: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(rst_n_out) |-> (low_cnt == len_q))
    else $error("Peripheral reset held for wrong number of cycles");
endmodule
`default_nettype wire

// file: src/pcs_ctrl.sv
/*
  Clock stabilisation, peripheral reset, clock-stop handshake, clock gating,
  pin high-impedance hold and pull enables, behind an AXI4-Lite slave.
  Assumes peripheral acknowledges arrive on mclk_in and the strap is a pin.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pcs_regs.svh"
module pcs_ctrl #(
  parameter int STAB_CYC = `PCS_STAB_CYC,
  parameter int IO_CYC_HI = `PCS_IO_HIZ_CYC_HI,
  parameter int IO_CYC_LO = `PCS_IO_HIZ_CYC_LO,
  parameter int NRST = 8
) (
  input wire logic mclk_in, // System clock, 200 MHz
  input wire logic nrst_in, // Chip reset, active low
  input wire logic clk_en_in, // Freezes all state when low
  input wire logic clk_sel_strap_in, // Clock-source strap pin
  input wire logic [5:0] periph_ack_in, // Clock-stop acknowledges
  input wire logic [15:0] s_axi_awaddr_in, // Write address
  input wire logic s_axi_awvalid_in, // Write address valid
  output logic s_axi_awready_out, // Write address ready
  input wire logic [31:0] s_axi_wdata_in, // Write data
  input wire logic [3:0] s_axi_wstrb_in, // Write strobes
  input wire logic s_axi_wvalid_in, // Write data valid
  output logic s_axi_wready_out, // Write data ready
  output logic [1:0] s_axi_bresp_out, // Write response
  output logic s_axi_bvalid_out, // Write response valid
  input wire logic s_axi_bready_in, // Write response ready
  input wire logic [15:0] s_axi_araddr_in, // Read address
  input wire logic s_axi_arvalid_in, // Read address valid
  output logic s_axi_arready_out, // Read address ready
  output logic [31:0] s_axi_rdata_out, // Read data
  output logic [1:0] s_axi_rresp_out, // Read response
  output logic s_axi_rvalid_out, // Read data valid
  input wire logic s_axi_rready_in, // Read data ready
  output logic clocks_released_out, // Device clocks running
  output logic pll_ref_osc_sel_out, // 1: oscillator, 0: clock pin
  output logic osc_en_out, // Crystal oscillator enable
  output logic io_hiz_out, // All pins high impedance
  output logic [95:0] io_pull_en_out, // Pull enables, six groups of 16
  output logic [31:0] periph_clk_en_out, // Peripheral clock enables
  output logic [5:0] clk_stop_req_out, // Clock-stop requests
  output logic [NRST-1:0] periph_rst_n_out // Peripheral resets, active low
);
  pcs_pkg::pcs_boot_e boot_q;
  pcs_pkg::pcs_wr_s wr;
  logic strap_sync;
  logic strap_q;
  logic [2:0] fill_cnt;
  logic [20:0] stab_cnt;
  logic [16:0] io_cnt;
  logic [16:0] io_target;
  logic [15:0] gate_lo;
  logic [15:0] gate_hi;
  logic [15:0] rst_len;
  logic [5:0] cs_req;
  logic [5:0] cs_ack;
  logic [NRST-1:0] rst_start;
  logic [NRST-1:0] rst_busy;
  logic [15:0] pull_q [6];
  logic aw_have;
  logic w_have;
  logic wr_fire;
  logic [15:0] ar_idx;
  logic [31:0] rd_data;
  logic rd_hit;
  logic wr_hit;
  logic [5:0] auto_idle;
  logic [31:0] next_clk_en;

  // Strap pin through the three-stage filter
  pcs_sync3 #(.W(1)) u_strap_sync (
    .clk_in(mclk_in),
    .rst_n_in(nrst_in),
    .ce_in(clk_en_in),
    .d_in(clk_sel_strap_in),
    .q_out(strap_sync)
  );

  // Start-up: capture strap, then with strap low hold clocks until the oscillator settles
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      boot_q <= pcs_pkg::BOOT_STRAP;
      fill_cnt <= '0;
      strap_q <= 1'b0;
      stab_cnt <= '0;
      clocks_released_out <= 1'b0;
      pll_ref_osc_sel_out <= 1'b1;
      osc_en_out <= 1'b1;
    end else if (clk_en_in) begin
      case (boot_q)
        pcs_pkg::BOOT_STRAP: begin
          fill_cnt <= fill_cnt + 3'h1;
          if (fill_cnt == `PCS_STRAP_FILL) begin
            strap_q <= strap_sync;
            pll_ref_osc_sel_out <= !strap_sync;
            osc_en_out <= !strap_sync;
            if (strap_sync) begin
              boot_q <= pcs_pkg::BOOT_RUN;
              clocks_released_out <= 1'b1;
            end else begin
              boot_q <= pcs_pkg::BOOT_WAIT;
            end
          end
        end
        pcs_pkg::BOOT_WAIT: begin
          if (stab_cnt == 21'(STAB_CYC - 1)) begin
            boot_q <= pcs_pkg::BOOT_RUN;
            clocks_released_out <= 1'b1;
          end else begin
            stab_cnt <= stab_cnt + 21'h1;
          end
        end
        pcs_pkg::BOOT_RUN: begin
          clocks_released_out <= 1'b1;
        end
        default: begin
          boot_q <= pcs_pkg::BOOT_STRAP;
        end
      endcase
    end
  end

  // Pin hold: high impedance through reset and a strap-dependent count after
  assign io_target = strap_q ? 17'(IO_CYC_HI) : 17'(IO_CYC_LO);
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      io_hiz_out <= 1'b1;
      io_cnt <= '0;
    end else if (clk_en_in && io_hiz_out) begin
      io_cnt <= io_cnt + 17'h1;
      if ((boot_q != pcs_pkg::BOOT_STRAP) && (io_cnt == io_target - 17'h1)) begin
        io_hiz_out <= 1'b0;
      end
    end
  end

  // Write channel: take address and data in either order
  assign wr_fire = aw_have && w_have && !s_axi_bvalid_out;
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out <= 1'b1;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `PCS_RESP_OKAY;
      wr <= '0;
    end else if (clk_en_in) begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_have <= 1'b1;
        s_axi_awready_out <= 1'b0;
        wr.idx <= {2'h0, s_axi_awaddr_in[15:2]};
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_have <= 1'b1;
        s_axi_wready_out <= 1'b0;
        wr.data <= s_axi_wdata_in[15:0];
        wr.strb <= s_axi_wstrb_in[1:0];
      end
      if (wr_fire) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= wr_hit ? `PCS_RESP_OKAY : `PCS_RESP_SLVERR;
      end
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out <= 1'b1;
      end
    end
  end

  // Merge byte lanes into a 16-bit register
  function automatic logic [15:0] merge(input logic [15:0] old, input pcs_pkg::pcs_wr_s w);
    merge = {w.strb[1] ? w.data[15:8] : old[15:8], w.strb[0] ? w.data[7:0] : old[7:0]};
  endfunction

  // Control registers written by software
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      gate_lo <= `PCS_GATE_RST;
      gate_hi <= `PCS_GATE_RST;
      rst_len <= `PCS_RST_CNT_RST;
      cs_req <= `PCS_CS_REQ_RST;
    end else if (clk_en_in && wr_fire) begin
      case (wr.idx)
        `PCS_IDX_GATE_LO: gate_lo <= merge(gate_lo, wr);
        `PCS_IDX_GATE_HI: gate_hi <= merge(gate_hi, wr);
        `PCS_IDX_RST_CNT: rst_len <= merge(rst_len, wr);
        `PCS_IDX_CLK_STOP: begin
          if (wr.strb[0]) begin
            cs_req <= wr.data[5:0];
          end
        end
        default: begin
          gate_lo <= gate_lo;
        end
      endcase
    end
  end

  // Pull enable registers, one bit per pin, on from reset
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < 6; i++) begin
        pull_q[i] <= `PCS_PULL_RST;
      end
    end else if (clk_en_in && wr_fire) begin
      case (wr.idx)
        `PCS_IDX_PULL_SER: pull_q[0] <= merge(pull_q[0], wr);
        `PCS_IDX_PULL_MISC: pull_q[1] <= merge(pull_q[1], wr);
        `PCS_IDX_PULL_MEM_D: pull_q[2] <= merge(pull_q[2], wr);
        `PCS_IDX_PULL_MEM_A: pull_q[3] <= merge(pull_q[3], wr);
        `PCS_IDX_PULL_MEM_C: pull_q[4] <= merge(pull_q[4], wr);
        `PCS_IDX_PULL_SDR_HOST: pull_q[5] <= merge(pull_q[5], wr);
        default: begin
          pull_q[0] <= pull_q[0];
        end
      endcase
    end
  end
  // Pull enables go straight to the pads, untouched by pin routing
  assign io_pull_en_out = {pull_q[5], pull_q[4], pull_q[3], pull_q[2], pull_q[1], pull_q[0]};

  // Decode of the write target
  always_comb begin
    case (wr.idx)
      `PCS_IDX_GATE_LO, `PCS_IDX_GATE_HI, `PCS_IDX_RST_CTRL, `PCS_IDX_RST_CNT,
      `PCS_IDX_CLK_STOP, `PCS_IDX_STATUS, `PCS_IDX_PULL_SER, `PCS_IDX_PULL_MISC,
      `PCS_IDX_PULL_MEM_D, `PCS_IDX_PULL_MEM_A, `PCS_IDX_PULL_MEM_C,
      `PCS_IDX_PULL_SDR_HOST: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Software reset triggers, one counter per peripheral
  assign rst_start = (wr_fire && (wr.idx == `PCS_IDX_RST_CTRL)) ? wr.data[NRST-1:0] : '0;
  for (genvar g = 0; g < NRST; g++) begin : g_rst
    pcs_rst_cnt #(.CW(16)) u_rst (
      .clk_in(mclk_in),
      .rst_n_in(nrst_in),
      .ce_in(clk_en_in),
      .start_in(rst_start[g]),
      .count_in(rst_len),
      .rst_n_out(periph_rst_n_out[g]),
      .busy_out(rst_busy[g])
    );
  end

  // Acknowledges and clock enables change on the same edge
  assign auto_idle = cs_req & periph_ack_in & `PCS_HS_AUTO_IDLE;
  assign next_clk_en = {32{clocks_released_out}} & ~{gate_hi, gate_lo} & ~{26'h0, auto_idle};
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cs_ack <= '0;
      periph_clk_en_out <= '0;
      clk_stop_req_out <= `PCS_CS_REQ_RST;
    end else if (clk_en_in) begin
      cs_ack <= periph_ack_in;
      periph_clk_en_out <= next_clk_en;
      clk_stop_req_out <= cs_req;
    end
  end

  // Read channel: one outstanding read, answered one cycle after acceptance
  assign ar_idx = {2'h0, s_axi_araddr_in[15:2]};
  always_comb begin
    rd_hit = 1'b1;
    rd_data = '0;
    case (ar_idx)
      `PCS_IDX_GATE_LO: rd_data[15:0] = gate_lo;
      `PCS_IDX_GATE_HI: rd_data[15:0] = gate_hi;
      `PCS_IDX_RST_CTRL: rd_data[NRST-1:0] = rst_busy;
      `PCS_IDX_RST_CNT: rd_data[15:0] = rst_len;
      `PCS_IDX_CLK_STOP: rd_data[13:0] = {cs_ack, 2'h0, cs_req};
      `PCS_IDX_STATUS: begin
        rd_data[`PCS_ST_RELEASED] = clocks_released_out;
        rd_data[`PCS_ST_IO_HIZ] = io_hiz_out;
        rd_data[`PCS_ST_STRAP] = strap_q;
        rd_data[`PCS_ST_OSC_EN] = osc_en_out;
      end
      `PCS_IDX_PULL_SER: rd_data[15:0] = pull_q[0];
      `PCS_IDX_PULL_MISC: rd_data[15:0] = pull_q[1];
      `PCS_IDX_PULL_MEM_D: rd_data[15:0] = pull_q[2];
      `PCS_IDX_PULL_MEM_A: rd_data[15:0] = pull_q[3];
      `PCS_IDX_PULL_MEM_C: rd_data[15:0] = pull_q[4];
      `PCS_IDX_PULL_SDR_HOST: rd_data[15:0] = pull_q[5];
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= '0;
      s_axi_rresp_out <= `PCS_RESP_OKAY;
    end else if (clk_en_in) begin
      if (s_axi_arvalid_in && s_axi_arready_out) begin
        s_axi_arready_out <= 1'b0;
        s_axi_rvalid_out <= 1'b1;
        s_axi_rdata_out <= rd_data;
        s_axi_rresp_out <= rd_hit ? `PCS_RESP_OKAY : `PCS_RESP_SLVERR;
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
        s_axi_arready_out <= 1'b1;
      end
    end
  end

  // Clocks stay off while the settling count runs
  AST_STAB_HOLD: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (boot_q != pcs_pkg::BOOT_RUN) |-> !clocks_released_out)
    else $error("Clocks released before stabilisation finished");

  AST_STAB_LEN: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (clocks_released_out && !strap_q) |-> (stab_cnt == 21'(STAB_CYC - 1)))
    else $error("Oscillator settling interval too short");

  AST_REF_SEL: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (boot_q != pcs_pkg::BOOT_STRAP) |-> (pll_ref_osc_sel_out == !strap_q))
    else $error("PLL reference source does not follow strap");

  AST_OSC_OFF: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    ((boot_q != pcs_pkg::BOOT_STRAP) && strap_q) |-> (!osc_en_out && clocks_released_out))
    else $error("Oscillator enabled with strap high");

  AST_AUTO_IDLE: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    ((auto_idle != 6'h0) && clk_en_in) |=> ((periph_clk_en_out[5:0] & $past(auto_idle)) == 6'h0))
    else $error("Clock still running after stop acknowledge");

  AST_GATE_NOW: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (wr_fire && clk_en_in && clocks_released_out && (wr.idx == `PCS_IDX_GATE_HI) && (wr.strb == 2'h3))
    |=> (clk_en_in |=> (periph_clk_en_out[31:16] == ~$past(wr.data, 2))))
    else $error("Gating write did not act on the next cycle");

  AST_IO_HOLD: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (boot_q == pcs_pkg::BOOT_STRAP) |-> io_hiz_out)
    else $error("Pins left high impedance too early");

  AST_IO_LEN: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    $fell(io_hiz_out) |-> (io_cnt == io_target))
    else $error("Pin hold count wrong for strap");

  AST_PULL_RST: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (io_cnt == 17'h0) |-> (&io_pull_en_out))
    else $error("Pull enables not all on after reset");

  AST_PULL_SW: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    !$stable(io_pull_en_out) |-> $past(wr_fire))
    else $error("Pull enable changed without a register write");
endmodule
`default_nettype wire

// file: tb/pcs_periph_model.sv
/*
  Peripheral side of the clock-stop handshake: each unit finishes its transfer
  in flight, then acknowledges. Assumes requests and acknowledges share mclk_in.
*/
`timescale 1ns/1ps
`default_nettype none
module pcs_periph_model (
  input wire logic mclk_in, // Clock
  input wire logic nrst_in, // Reset, active low
  input wire logic [5:0] req_in, // Clock-stop requests
  input wire logic [3:0] busy_len_in, // Transfer cycles left at request
  output logic [5:0] ack_out // Acknowledges
);
  logic [3:0] left [6];
  // Count down the open transfer, then acknowledge; drop ack with request
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ack_out <= 6'h00;
      for (int i = 0; i < 6; i++) left[i] <= 4'h0;
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (!req_in[i]) begin
          ack_out[i] <= 1'b0;
          left[i] <= busy_len_in;
        end else if (left[i] != 4'h0) begin
          left[i] <= left[i] - 4'h1;
        end else begin
          ack_out[i] <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/pcs_ctrl_tb.sv
/*
  Self-checking bench for pcs_ctrl with a peripheral handshake model.
  Assumes short stabilisation and pin-hold counts set by parameters.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pcs_regs.svh"
module pcs_ctrl_tb;
  localparam int STAB = 20;
  localparam int IO_LO = 60;
  localparam int IO_HI = 40;
  logic clk = 0, rst_n = 0, strap = 0, awv = 0, wv = 0, arv = 0, ce = 1;
  logic [5:0] auto_set = `PCS_HS_AUTO_IDLE;
  logic awr, wrdy, bv, arr, rv, rel, osc_sel, osc_en, hiz;
  logic [15:0] aw = 0, ar = 0, q, d;
  logic [31:0] wd = 0, rdat, cen;
  logic [1:0] br, rr, resp;
  logic [95:0] pull;
  logic [5:0] req, ack;
  logic [7:0] prst;
  logic [3:0] blen = 0;
  logic [15:0] pidx [6] = '{16'h1c17, 16'h1c18, 16'h1c4c, 16'h1c4d, 16'h1c4f, 16'h1c50};
  int seed = 32'h8d61, fail_count = 0, n_compared = 0, rcnt = 0, rg = 0, t_rel, t_hiz, i, n;
  pcs_ctrl #(.STAB_CYC(STAB), .IO_CYC_HI(IO_HI), .IO_CYC_LO(IO_LO), .NRST(8)) i_dut (
    .mclk_in(clk), .nrst_in(rst_n), .clk_en_in(ce), .clk_sel_strap_in(strap),
    .periph_ack_in(ack), .s_axi_awaddr_in(aw), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
    .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrdy),
    .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(1'b1), .s_axi_araddr_in(ar),
    .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rdat), .s_axi_rresp_out(rr),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(1'b1), .clocks_released_out(rel),
    .pll_ref_osc_sel_out(osc_sel), .osc_en_out(osc_en), .io_hiz_out(hiz), .io_pull_en_out(pull),
    .periph_clk_en_out(cen), .clk_stop_req_out(req), .periph_rst_n_out(prst));
  pcs_periph_model i_periph (.mclk_in(clk), .nrst_in(rst_n), .req_in(req), .busy_len_in(blen), .ack_out(ack));
  // Clock, reset-length monitor and watchdog
  always #2.5 clk = ~clk;
  always @(negedge clk) if (prst[rg] === 1'b0) rcnt++;
  initial #200000 begin
    fail_count++;
    end_of_test();
  end
  // Value comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bus write, response kept in resp
  task automatic wr(input logic [15:0] idx, input logic [15:0] v);
    aw <= {idx[13:0], 2'h0};
    wd <= {16'h0, v};
    awv <= 1'b1;
    wv <= 1'b1;
    forever begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
      if (bv) break;
    end
    resp = br;
  endtask
  // Bus read, waits for the answer; only the watchdog ends a hang
  task automatic rd(input logic [15:0] idx, output logic [15:0] v);
    ar <= {idx[13:0], 2'h0};
    arv <= 1'b1;
    forever begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    v = rdat[15:0];
    resp = rr;
  endtask
  task automatic end_of_test;
    $display("compared %0d, failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Reset with a given strap, then count enabled edges to release and pin hold end
  task automatic boot(input logic s, input int e_rel, input int e_hiz);
    rst_n <= 1'b0;
    strap <= s;
    repeat (10) @(posedge clk);
    chk(hiz, 1);
    chk(&pull, 1);
    rst_n <= 1'b1;
    t_rel = 0;
    t_hiz = 0;
    for (int k = 1; k <= 80; k++) begin
      @(negedge clk);
      if (!rel && cen !== 0) t_rel = 999;
      if (rel && t_rel == 0) t_rel = k - 1;
      if (!hiz && t_hiz == 0) t_hiz = k - 1;
    end
    chk(t_rel, e_rel);
    chk(t_hiz, e_hiz);
    chk({osc_sel, osc_en}, {2{!s}});
    @(posedge clk);
  endtask
  // Main sequence
  initial begin
    boot(1'b0, `PCS_STRAP_FILL + 1 + STAB, IO_LO);
    for (i = 0; i < 6; i++) begin
      d = 16'($random(seed));
      wr(pidx[i], d);
      rd(pidx[i], q);
      chk(q, d);
      chk(pull[i*16 +: 16], d);
    end
    d = 16'(3 + ($unsigned($random(seed)) % 8));
    rg = $unsigned($random(seed)) % 8;
    wr(`PCS_IDX_RST_CNT, d);
    rcnt = 0;
    wr(`PCS_IDX_RST_CTRL, 16'h1 << rg);
    // Three frozen edges mid-count stretch the reset by three cycles
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    repeat (20) @(posedge clk);
    chk(rcnt, d + 3);
    for (i = 0; i < 6; i++) begin
      blen <= 4'($random(seed));
      wr(`PCS_IDX_CLK_STOP, 16'h1 << i);
      q = 0;
      for (n = 0; n < 30 && q[8+i] !== 1'b1; n++) rd(`PCS_IDX_CLK_STOP, q);
      @(negedge clk);
      chk({req[i], cen[i], q[8+i]}, {1'b1, !auto_set[i], 1'b1});
      wr(`PCS_IDX_GATE_LO, 16'h1 << i);
      @(negedge clk);
      chk(cen[i], 0);
      wr(`PCS_IDX_GATE_LO, 16'h0);
      wr(`PCS_IDX_CLK_STOP, 16'h0);
      repeat (4) @(posedge clk);
      rd(`PCS_IDX_CLK_STOP, q);
      chk({q[8+i], cen[i]}, 2'h1);
    end
    d = 16'($random(seed));
    wr(`PCS_IDX_GATE_HI, d);
    @(negedge clk);
    chk(cen[31:16], 16'(~d));
    // Mid-run reset with the strap high
    boot(1'b1, `PCS_STRAP_FILL + 1, IO_HI);
    wr(16'h1c60, 16'h1);
    chk(resp, `PCS_RESP_SLVERR);
    rd(16'h1c60, q);
    chk(resp, `PCS_RESP_SLVERR);
    chk(q, 0);
    end_of_test();
  end
endmodule
`default_nettype wire
